// ---- gpm_pkg.sv ----
/*
  Package for the low pin function mux: register offsets, field positions, reset values,
  function select codes.
  Assumes a 16-bit register port addressed by byte offset.
*/
package gpm_pkg;
  localparam logic [5:0] ADDR_FUNC_SEL = 6'h00;
  localparam logic [5:0] ADDR_DRIVE_EN = 6'h04;
  localparam logic [5:0] ADDR_OUT_VALUE = 6'h14;
  localparam logic [15:0] FUNC_SEL_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_EN_RESET = 16'h0000;
  localparam logic [7:0] OUT_VALUE_RESET = 8'h00;
  localparam int PIN3_LSB = 6;
  localparam int PIN2_LSB = 4;
  localparam int PIN1_LSB = 2;
  localparam int PIN0_LSB = 0;
  localparam int PORT_PINS = 8;
  localparam int LOW_PINS = 4;
  typedef enum logic [1:0] {
    CODE_A = 2'b00,
    CODE_SEQ_TRIGGER = 2'b01,
    CODE_SYNC = 2'b10,
    CODE_D = 2'b11
  } gpm_code_type;
  // what a low pin carries out once its select code is decoded
  typedef enum logic [2:0] {
    SRC_GPIO = 3'b000,
    SRC_TRIGGER_IN = 3'b001,
    SRC_SYNC = 3'b010,
    SRC_IRQ0 = 3'b011,
    SRC_POR = 3'b100,
    SRC_EXTERNAL_CLOCK_INPUT_IN = 3'b101,
    SRC_SLEEP = 3'b110
  } gpm_source_type;
endpackage

// ---- gpm_pin_decode.sv ----
/*
  Decoder from a pin index and its 2-bit select code to the source on that pin.
  Assumes the caller passes a constant pin index from 0 to 3.
*/
`timescale 1ns/10ps
`default_nettype none
module gpm_pin_decode #(
  parameter int PIN = 0
) (
  // selector
  input wire logic [1:0] code,
  // decoded source
  output var gpm_pkg::gpm_source_type source
);
  always_comb begin
    source = gpm_pkg::SRC_GPIO;
    if (code == gpm_pkg::CODE_SEQ_TRIGGER) begin
      source = gpm_pkg::SRC_TRIGGER_IN;
    end else if (code == gpm_pkg::CODE_SYNC) begin
      source = gpm_pkg::SRC_SYNC;
    end else if (code == gpm_pkg::CODE_A) begin
      if (PIN == 0) begin
        source = gpm_pkg::SRC_IRQ0;
      end else if (PIN == 2) begin
        source = gpm_pkg::SRC_POR;
      end else begin
        source = gpm_pkg::SRC_GPIO;
      end
    end else begin
      if (PIN == 0) begin
        source = gpm_pkg::SRC_GPIO;
      end else if (PIN == 1) begin
        source = gpm_pkg::SRC_SLEEP;
      end else if (PIN == 2) begin
        source = gpm_pkg::SRC_EXTERNAL_CLOCK_INPUT_IN;
      end else begin
        source = gpm_pkg::SRC_IRQ0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- gpm_pin_mux.sv ----
/*
  Pin function mux for the eight-pin port: function select for pins 0 to 3, per-pin drive
  enable, output value, and pin output muxing.
  Assumes a synchronous register port with read data one cycle after the read strobe, and
  pin inputs synchronous to clk.
*/
// Behaviour
// - pin 3 select bits 7:6: gpio, trigger 3, sync 3, interrupt 0
// - pin 2 select bits 5:4: por out, trigger 2, sync 2, external clock in
// - pin 1 select bits 3:2: gpio, trigger 1, sync 1, sleep flag
// - pin 0 select bits 1:0: interrupt 0, trigger 0, sync 0, gpio
// - pin 1 in sleep mode drives high while the device hibernates
// - drive enable bits 7:0 gate each pin's driver except on interrupt, por and sleep outputs and trigger and clock inputs, all off at reset
// - an enabled gpio pin shows its output value bit
// - sync output reaches a pin only with drive enabled and sync selected
// - interrupt pin high while interrupt is pending, low once cleared
`timescale 1ns/10ps
`default_nettype none
module gpm_pin_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // device events
  input wire logic [7:0] sequencerSyncOutputs,
  input wire logic interrupt0,
  input wire logic porIndication,
  input wire logic hibernate,
  // pins
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOen,
  // decoded inputs
  output logic [3:0] sequenceTrigger,
  output logic externalClockInput
);
  logic [15:0] portPinFunctionSelect;
  logic [7:0] pinDriveEnableBits;
  logic [7:0] portOutputValue;
  logic [15:0] next_portPinFunctionSelect;
  logic [7:0] next_pinDriveEnableBits;
  logic [7:0] next_portOutputValue;
  logic [15:0] next_regRdata;
  logic [7:0] next_pinOut;
  logic [7:0] next_pinOen;
  logic [3:0] next_sequenceTrigger;
  logic next_externalClockInput;
  gpm_pkg::gpm_source_type pinSource [gpm_pkg::LOW_PINS];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_comb begin
    next_portPinFunctionSelect = portPinFunctionSelect;
    next_pinDriveEnableBits = pinDriveEnableBits;
    next_portOutputValue = portOutputValue;
    next_regRdata = 16'h0000;
    if (regWrite) begin
      if (regAddr == gpm_pkg::ADDR_FUNC_SEL) begin
        next_portPinFunctionSelect = regWdata;
      end else if (regAddr == gpm_pkg::ADDR_DRIVE_EN) begin
        next_pinDriveEnableBits = regWdata[7:0];
      end else if (regAddr == gpm_pkg::ADDR_OUT_VALUE) begin
        next_portOutputValue = regWdata[7:0];
      end
    end
    if (regRead) begin
      if (regAddr == gpm_pkg::ADDR_FUNC_SEL) begin
        next_regRdata = portPinFunctionSelect;
      end else if (regAddr == gpm_pkg::ADDR_DRIVE_EN) begin
        next_regRdata = {8'h00, pinDriveEnableBits};
      end else if (regAddr == gpm_pkg::ADDR_OUT_VALUE) begin
        next_regRdata = {8'h00, portOutputValue};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      portPinFunctionSelect <= gpm_pkg::FUNC_SEL_RESET;
      pinDriveEnableBits <= gpm_pkg::DRIVE_EN_RESET[7:0];
      portOutputValue <= gpm_pkg::OUT_VALUE_RESET;
      regRdata <= 16'h0000;
    end else begin
      portPinFunctionSelect <= next_portPinFunctionSelect;
      pinDriveEnableBits <= next_pinDriveEnableBits;
      portOutputValue <= next_portOutputValue;
      regRdata <= next_regRdata;
    end
  end

  // ------------------------------------------------------------
  // pin muxing
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < gpm_pkg::LOW_PINS; gi++) begin : gLow
      gpm_pin_decode #(
        .PIN(gi)
      ) uDecode (
        .code(portPinFunctionSelect[2*gi+1:2*gi]),
        .source(pinSource[gi])
      );
    end
  endgenerate

  // pins 4 to 7 have no selector here and stay plain gpio
  always_comb begin
    next_pinOut = portOutputValue;
    next_pinOen = ~pinDriveEnableBits;
    next_sequenceTrigger = 4'h0;
    next_externalClockInput = 1'b0;
    for (int i = 0; i < gpm_pkg::LOW_PINS; i++) begin
      case (pinSource[i])
        gpm_pkg::SRC_SYNC: begin
          next_pinOut[i] = sequencerSyncOutputs[i];
        end
        gpm_pkg::SRC_IRQ0: begin
          next_pinOut[i] = interrupt0;
          next_pinOen[i] = 1'b0;
        end
        gpm_pkg::SRC_POR: begin
          next_pinOut[i] = porIndication;
          next_pinOen[i] = 1'b0;
        end
        gpm_pkg::SRC_SLEEP: begin
          next_pinOut[i] = hibernate;
          next_pinOen[i] = 1'b0;
        end
        gpm_pkg::SRC_TRIGGER_IN: begin
          next_sequenceTrigger[i] = pinIn[i];
          next_pinOen[i] = 1'b1;
        end
        gpm_pkg::SRC_EXTERNAL_CLOCK_INPUT_IN: begin
          next_externalClockInput = pinIn[i];
          next_pinOen[i] = 1'b1;
        end
        default: begin
          next_pinOut[i] = portOutputValue[i];
        end
      endcase
    end
  end

  // registered so every pin output comes from a flop; one cycle of latency
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinOut <= 8'h00;
      pinOen <= 8'hFF;
      sequenceTrigger <= 4'h0;
      externalClockInput <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
      pinOen <= next_pinOen;
      sequenceTrigger <= next_sequenceTrigger;
      externalClockInput <= next_externalClockInput;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  drive_off_reset_a: assert property ($rose(rstn) |-> pinOen == 8'hFF)
    else $error("pins driven right after reset");
  // pins 7:4 have no selector, so their enable follows the written bits two edges later
  oen_gate_a: assert property (regWrite && regAddr == gpm_pkg::ADDR_DRIVE_EN
      |-> ##2 pinOen[7:4] == ~$past(regWdata[7:4], 2))
    else $error("drive enable not applied");
  reserved_zero_a: assert property (regRead && regAddr == gpm_pkg::ADDR_DRIVE_EN
      |=> regRdata[15:8] == 8'h00)
    else $error("reserved bits not zero");
  gpio_value_a: assert property (portPinFunctionSelect[7:6] == 2'b00 && pinDriveEnableBits[3]
      |=> pinOut[3] == $past(portOutputValue[3]) && !pinOen[3])
    else $error("gpio value not on pin");
  sync_path_a: assert property (portPinFunctionSelect[7:6] == 2'b10 && pinDriveEnableBits[3]
      |=> pinOut[3] == $past(sequencerSyncOutputs[3]) && !pinOen[3])
    else $error("sync output not routed");
  sync_gated_a: assert property (portPinFunctionSelect[7:6] == 2'b10 && !pinDriveEnableBits[3]
      |=> pinOen[3])
    else $error("sync drives without enable");
  irq_pin_a: assert property (portPinFunctionSelect[1:0] == 2'b00
      |=> pinOut[0] == $past(interrupt0) && !pinOen[0])
    else $error("interrupt pin wrong");
  sleep_flag_a: assert property (portPinFunctionSelect[3:2] == 2'b11
      |=> pinOut[1] == $past(hibernate) && !pinOen[1])
    else $error("sleep flag wrong");
  por_pin_a: assert property (portPinFunctionSelect[5:4] == 2'b00
      |=> pinOut[2] == $past(porIndication))
    else $error("por pin wrong");
  external_clock_input_in_a: assert property (portPinFunctionSelect[5:4] == 2'b11
      |=> externalClockInput == $past(pinIn[2]) && pinOen[2])
    else $error("external clock not taken");
  trigger_in_a: assert property (portPinFunctionSelect[7:6] == 2'b01
      |=> sequenceTrigger[3] == $past(pinIn[3]))
    else $error("trigger 3 not taken");

  sleep_seen_c: cover property (portPinFunctionSelect[3:2] == 2'b11 ##1 pinOut[1]);
  irq_seen_c: cover property (portPinFunctionSelect[7:6] == 2'b11 ##1 pinOut[3] ##1 !pinOut[3]);
  sync_seen_c: cover property (pinDriveEnableBits[0] && portPinFunctionSelect[1:0] == 2'b10
      ##1 pinOut[0]);
endmodule
`default_nettype wire

// ---- gpm_host_model.sv ----
/*
  Pin-side model of the host and external devices: works out each pin's level from the
  device driver and the host driver and feeds it back as the pin input.
  Assumes pinOen is active low and that the host never fights a driving device pin.
*/
`timescale 1ns/10ps
`default_nettype none
module gpm_host_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOen,
  // host side
  input wire logic [7:0] hostEn,
  input wire logic [7:0] hostVal,
  output logic [7:0] pinIn
);
  logic [7:0] floatPat = 8'h55;
  // undriven pins wander every cycle so a stale level never passes for a good one
  always @(posedge clk) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinIn[i] = !pinOen[i] ? pinOut[i] : (hostEn[i] ? hostVal[i] : floatPat[i]);
    end
  end
endmodule
`default_nettype wire

// ---- gpm_pin_mux_test.sv ----
/*
  Self-checking testbench for the low pin function mux.
  Assumes registers settle on the pins within three cycles of a write.
*/
`timescale 1ns/10ps
`default_nettype none
module gpm_pin_mux_test;
  logic clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWdata = 16'h0000, rdv;
  logic [7:0] syncOut = 8'h00, hostEn = 8'h00, hostVal = 8'h00;
  logic irq = 1'b0, por = 1'b0, hib = 1'b0, external_clock_input;
  logic [15:0] regRdata;
  logic [7:0] pinIn, pinOut, pinOen;
  logic [3:0] trig;
  int n_errors = 0, cmp_count = 0;
  gpm_pin_mux u_gpm_pin_mux (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .sequencerSyncOutputs(syncOut), .interrupt0(irq), .porIndication(por),
    .hibernate(hib), .pinIn(pinIn), .pinOut(pinOut), .pinOen(pinOen),
    .sequenceTrigger(trig), .externalClockInput(external_clock_input));
  gpm_host_model u_gpm_host_model (.clk(clk), .pinOut(pinOut), .pinOen(pinOen),
    .hostEn(hostEn), .hostVal(hostVal), .pinIn(pinIn));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic cfg(input logic [15:0] sel, input logic [15:0] en);
    wr(gpm_pkg::ADDR_FUNC_SEL, sel);
    wr(gpm_pkg::ADDR_DRIVE_EN, en);
    wt(3);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    wt(3);
    chk({8'h00, pinOen}, 16'h00FA);
    rd(gpm_pkg::ADDR_DRIVE_EN, rdv);
    chk(rdv, 16'h0000);
    rd(gpm_pkg::ADDR_FUNC_SEL, rdv);
    chk(rdv, 16'h0000);
    wr(gpm_pkg::ADDR_DRIVE_EN, 16'hFFFF);
    rd(gpm_pkg::ADDR_DRIVE_EN, rdv);
    chk(rdv, 16'h00FF);
    wr(6'h3C, 16'hFFFF);
    rd(6'h3C, rdv);
    chk(rdv, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_gpio;
    por <= 1'b1;
    wr(gpm_pkg::ADDR_OUT_VALUE, 16'h00A5);
    cfg(16'h0003, 16'h00FB);
    chk({8'h00, pinOen}, 16'h0000);
    chk({8'h00, pinOut}, 16'h00A5);
    cfg(16'h0003, 16'h0000);
    chk({8'h00, pinOen}, 16'h00FB);
    por <= 1'b0;
    wt(3);
    chk({15'h0, pinOut[2]}, 16'h0000);
    $display("t_gpio done");
  endtask
  task automatic t_sync;
    syncOut <= 8'h05;
    cfg(16'h00AA, 16'h000F);
    chk({12'h0, pinOen[3:0]}, 16'h0000);
    chk({12'h0, pinOut[3:0]}, 16'h0005);
    cfg(16'h00AA, 16'h0000);
    chk({12'h0, pinOen[3:0]}, 16'h000F);
    $display("t_sync done");
  endtask
  task automatic t_irq;
    cfg(16'h00C0, 16'h0000);
    irq <= 1'b1;
    wt(2);
    chk({14'h0, pinOut[3], pinOut[0]}, 16'h0003);
    chk({14'h0, pinOen[3], pinOen[0]}, 16'h0000);
    irq <= 1'b0;
    wt(2);
    chk({14'h0, pinOut[3], pinOut[0]}, 16'h0000);
    $display("t_irq done");
  endtask
  task automatic t_trig;
    hostEn <= 8'h0F;
    hostVal <= 8'h0A;
    cfg(16'h0055, 16'h000F);
    chk({12'h0, pinOen[3:0]}, 16'h000F);
    chk({12'h0, trig}, 16'h000A);
    hostVal <= 8'h04;
    cfg(16'h0030, 16'h0000);
    chk({15'h0, external_clock_input}, 16'h0001);
    chk({12'h0, trig}, 16'h0000);
    hostEn <= 8'h00;
    $display("t_trig done");
  endtask
  task automatic t_sleep;
    int n;
    cfg(16'h000C, 16'h0000);
    hib <= 1'b1;
    n = 0;
    while (pinIn[1] !== 1'b1 && n < 10) begin
      wt(1);
      n++;
    end
    chk({15'h0, pinIn[1]}, 16'h0001);
    chk({15'h0, pinOen[1]}, 16'h0000);
    hib <= 1'b0;
    wt(2);
    chk({15'h0, pinOut[1]}, 16'h0000);
    hib <= 1'b1;
    $display("t_sleep done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_gpio();
    t_sync();
    t_irq();
    t_trig();
    t_sleep();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
